// [octal_uart_mem_reg_decode_consts.vh]
`ifndef OCTAL_UART_MEM_REG_DECODE_CONSTS_VH
`define OCTAL_UART_MEM_REG_DECODE_CONSTS_VH

// Channel window layout
`define CHAN_STRIDE 12'h200
`define CHAN_MSB 11
`define CHAN_LSB 9
`define WIN_DATA 2'h2
`define WIN_STAT 2'h3
`define REG_AREA 4'h0

// Register offsets inside a channel window
`define OFF_HOLD 5'h00
`define OFF_IRQ_EN 5'h01
`define OFF_IRQ_ST 5'h02
`define OFF_LINE_CTL 5'h04
`define OFF_LINE_ST 5'h05
`define OFF_MODEM_ST 5'h06
`define OFF_SPECIAL 5'h07
`define OFF_DIV_LO 5'h08
`define OFF_DIV_HI 5'h09
`define OFF_ENH 5'h0A
`define OFF_RESUME1 5'h0B
`define OFF_RESUME2 5'h0C
`define OFF_PAUSE1 5'h0D
`define OFF_PAUSE2 5'h0E
`define OFF_ADV 5'h0F
`define OFF_TX_TRIG 5'h10
`define OFF_RX_TRIG 5'h11
`define OFF_FLOW_LO 5'h12
`define OFF_FLOW_HI 5'h13
`define OFF_PRESCALE 5'h14
`define OFF_RX_CNT 5'h15
`define OFF_TX_CNT 5'h16
`define OFF_GLOBAL_LS 5'h17

// Field positions
`define SEL_ERR_CNT_BIT 6
`define SEL_TX_CNT_BIT 7
`define FLUSH_RX_BIT 1
`define FLUSH_TX_BIT 2
`define LS_RX_READY_BIT 0
`define LS_RX_FULL_BIT 1
`define LS_TX_ROOM_BIT 5
`define LS_TX_EMPTY_BIT 6

// Values
`define IRQ_NONE 8'hC1
`define RESET_BYTE 8'h00
`define ERR_CNT_MAX 8'hFF

`endif

// [octal_uart_mem_reg_decode.v]
`include "octal_uart_mem_reg_decode_consts.vh"

module octal_uart_mem_reg_decode #(
    parameter DL = 7
) (
    input wire clk, // 250 MHz clock
    input wire reset_n, // Async reset, active low
    input wire [11:0] mem_addr, // Byte offset from second base register
    input wire mem_rd, // One-cycle read strobe
    input wire mem_wr, // One-cycle write strobe
    input wire [7:0] mem_wdata, // Write data
    output reg [7:0] mem_rdata_r, // Read data, cycle after strobe
    output reg mem_ack_r, // Access done pulse
    input wire rx_push, // Receiver delivers a byte
    input wire [2:0] rx_push_chan, // Channel of delivered byte
    input wire [7:0] rx_push_data, // Delivered byte
    input wire [7:0] rx_push_status, // Line state of delivered byte
    input wire tx_pop, // Transmitter requests a byte
    input wire [2:0] tx_pop_chan, // Channel requested
    output reg [7:0] tx_data_r, // Byte for transmitter
    output reg tx_valid_r // Pulse: tx_data_r is fresh
);

    localparam DEPTH = 1 << DL;
    localparam [DL:0] FULL_CNT = {1'b1, {DL{1'b0}}};
    localparam [DL:0] ZERO_CNT = {(DL+1){1'b0}};
    localparam [DL:0] ONE_CNT = {{DL{1'b0}}, 1'b1};

    function [DL+2:0] slot;
        input [2:0] c;
        input [DL-1:0] p;
        begin
            slot = {c, p};
        end
    endfunction

    function [7:0] to_byte;
        input [DL:0] v;
        reg [15:0] t;
        begin
            t = {{(15-DL){1'b0}}, v};
            to_byte = t[7:0];
        end
    endfunction

    function is_stored;
        input [4:0] o;
        begin
            case (o)
                `OFF_IRQ_EN,
                `OFF_LINE_CTL,
                `OFF_SPECIAL,
                `OFF_DIV_LO,
                `OFF_DIV_HI,
                `OFF_ENH,
                `OFF_RESUME1,
                `OFF_RESUME2,
                `OFF_PAUSE1,
                `OFF_PAUSE2,
                `OFF_ADV,
                `OFF_TX_TRIG,
                `OFF_RX_TRIG,
                `OFF_FLOW_LO,
                `OFF_FLOW_HI,
                `OFF_PRESCALE,
                `OFF_TX_CNT,
                `OFF_GLOBAL_LS: is_stored = 1'b1;
                default: is_stored = 1'b0;
            endcase
        end
    endfunction

    // Fill count step; push and pop together leave it unchanged
    function [DL:0] next_count;
        input [DL:0] cnt;
        input up;
        input down;
        begin
            next_count = cnt;
            if (up && !down) begin
                next_count = cnt + ONE_CNT;
            end else if (down && !up) begin
                next_count = cnt - ONE_CNT;
            end
        end
    endfunction

    reg [1:0] rst_sync_r;
    wire rst_n = rst_sync_r[1];

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    reg [7:0] rx_mem [0:8*DEPTH-1];
    reg [7:0] rx_stat_mem [0:8*DEPTH-1];
    reg [7:0] tx_mem [0:8*DEPTH-1];
    reg [DL-1:0] rx_rd_r [0:7];
    reg [DL-1:0] rx_wr_r [0:7];
    reg [DL-1:0] tx_rd_r [0:7];
    reg [DL-1:0] tx_wr_r [0:7];
    reg [DL:0] rx_cnt_r [0:7];
    reg [DL:0] tx_cnt_r [0:7];
    reg [7:0] err_cnt_r [0:7];
    reg [7:0] cfg_mem [0:255];
    reg [7:0] rd_nxt;
    integer i;
    integer j;
    integer k;
    integer m;

    wire [2:0] h_chan = mem_addr[`CHAN_MSB:`CHAN_LSB];
    wire [8:0] h_off = mem_addr[`CHAN_LSB-1:0];
    wire h_wr = mem_wr;
    wire h_rd = mem_rd & ~mem_wr;
    wire reg_area = (h_off[8:5] == `REG_AREA);
    wire [4:0] r_off = h_off[4:0];
    wire [7:0] cfg_idx = {h_chan, r_off};
    wire win_data = (h_off[8:7] == `WIN_DATA);
    wire win_stat = (h_off[8:7] == `WIN_STAT);
    wire [DL+2:0] win_slot = slot(h_chan, h_off[DL-1:0]);
    wire at_hold = reg_area & (r_off == `OFF_HOLD);
    wire at_qctl = reg_area & (r_off == `OFF_IRQ_ST);
    wire rx_empty_h = (rx_cnt_r[h_chan] == ZERO_CNT);
    wire [7:0] special_h = cfg_mem[{h_chan, `OFF_SPECIAL}];

    wire pop_rx = h_rd & at_hold & ~rx_empty_h;
    wire push_tx = h_wr & at_hold & (tx_cnt_r[h_chan] != FULL_CNT);
    wire flush_rx = h_wr & at_qctl & mem_wdata[`FLUSH_RX_BIT];
    wire flush_tx = h_wr & at_qctl & mem_wdata[`FLUSH_TX_BIT];
    wire push_rx = rx_push & (rx_cnt_r[rx_push_chan] != FULL_CNT);
    wire pop_tx = tx_pop & (tx_cnt_r[tx_pop_chan] != ZERO_CNT);

    // One bit per channel for each queue event
    wire [7:0] rx_in_hit = push_rx ? (8'h01 << rx_push_chan) : 8'h00;
    wire [7:0] rx_out_hit = pop_rx ? (8'h01 << h_chan) : 8'h00;
    wire [7:0] rx_clr_hit = flush_rx ? (8'h01 << h_chan) : 8'h00;
    wire [7:0] tx_in_hit = push_tx ? (8'h01 << h_chan) : 8'h00;
    wire [7:0] tx_out_hit = pop_tx ? (8'h01 << tx_pop_chan) : 8'h00;
    wire [7:0] tx_clr_hit = flush_tx ? (8'h01 << h_chan) : 8'h00;

    // Receive queue pointers; a flush beats a same-cycle push
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < 8; i = i + 1) begin
                rx_rd_r[i] <= {DL{1'b0}};
                rx_wr_r[i] <= {DL{1'b0}};
                rx_cnt_r[i] <= ZERO_CNT;
            end
        end else begin
            for (i = 0; i < 8; i = i + 1) begin
                if (rx_clr_hit[i]) begin
                    rx_rd_r[i] <= {DL{1'b0}};
                    rx_wr_r[i] <= {DL{1'b0}};
                    rx_cnt_r[i] <= ZERO_CNT;
                end else begin
                    if (rx_in_hit[i]) begin
                        rx_wr_r[i] <= rx_wr_r[i] + 1'b1;
                    end
                    if (rx_out_hit[i]) begin
                        rx_rd_r[i] <= rx_rd_r[i] + 1'b1;
                    end
                    rx_cnt_r[i] <= next_count(rx_cnt_r[i], rx_in_hit[i], rx_out_hit[i]);
                end
            end
        end
    end

    // Transmit queue pointers
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (j = 0; j < 8; j = j + 1) begin
                tx_rd_r[j] <= {DL{1'b0}};
                tx_wr_r[j] <= {DL{1'b0}};
                tx_cnt_r[j] <= ZERO_CNT;
            end
        end else begin
            for (j = 0; j < 8; j = j + 1) begin
                if (tx_clr_hit[j]) begin
                    tx_rd_r[j] <= {DL{1'b0}};
                    tx_wr_r[j] <= {DL{1'b0}};
                    tx_cnt_r[j] <= ZERO_CNT;
                end else begin
                    if (tx_in_hit[j]) begin
                        tx_wr_r[j] <= tx_wr_r[j] + 1'b1;
                    end
                    if (tx_out_hit[j]) begin
                        tx_rd_r[j] <= tx_rd_r[j] + 1'b1;
                    end
                    tx_cnt_r[j] <= next_count(tx_cnt_r[j], tx_in_hit[j], tx_out_hit[j]);
                end
            end
        end
    end

    // Received bytes flagged with any line error, saturating
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (k = 0; k < 8; k = k + 1) begin
                err_cnt_r[k] <= `RESET_BYTE;
            end
        end else begin
            for (k = 0; k < 8; k = k + 1) begin
                if (rx_in_hit[k] && rx_push_status != `RESET_BYTE &&
                    err_cnt_r[k] != `ERR_CNT_MAX) begin
                    err_cnt_r[k] <= err_cnt_r[k] + 8'h01;
                end
            end
        end
    end

    // Queue storage, no reset needed
    always @(posedge clk) begin
        if (push_rx) begin
            rx_mem[slot(rx_push_chan, rx_wr_r[rx_push_chan])] <= rx_push_data;
            rx_stat_mem[slot(rx_push_chan, rx_wr_r[rx_push_chan])] <= rx_push_status;
        end
        if (h_wr && win_data) begin
            rx_mem[win_slot] <= mem_wdata;
        end
        if (h_wr && win_stat) begin
            rx_stat_mem[win_slot] <= mem_wdata;
        end
        if (push_tx) begin
            tx_mem[slot(h_chan, tx_wr_r[h_chan])] <= mem_wdata;
        end
    end

    // Plain configuration registers
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (m = 0; m < 256; m = m + 1) begin
                cfg_mem[m] <= `RESET_BYTE;
            end
        end else if (h_wr && reg_area && is_stored(r_off)) begin
            cfg_mem[cfg_idx] <= mem_wdata;
        end
    end

    always @* begin
        rd_nxt = `RESET_BYTE;
        if (win_data) begin
            rd_nxt = rx_mem[win_slot];
        end else if (win_stat) begin
            rd_nxt = rx_stat_mem[win_slot];
        end else if (reg_area) begin
            case (r_off)
                `OFF_HOLD: begin
                    // Empty queue reads zero
                    rd_nxt = rx_empty_h ? `RESET_BYTE :
                             rx_mem[slot(h_chan, rx_rd_r[h_chan])];
                end
                `OFF_IRQ_ST: rd_nxt = `IRQ_NONE;
                `OFF_LINE_ST: begin
                    rd_nxt[`LS_RX_READY_BIT] = ~rx_empty_h;
                    rd_nxt[`LS_RX_FULL_BIT] = (rx_cnt_r[h_chan] == FULL_CNT);
                    rd_nxt[`LS_TX_ROOM_BIT] = (tx_cnt_r[h_chan] != FULL_CNT);
                    rd_nxt[`LS_TX_EMPTY_BIT] = (tx_cnt_r[h_chan] == ZERO_CNT);
                end
                `OFF_DIV_LO, `OFF_DIV_HI: rd_nxt = `RESET_BYTE;
                `OFF_RX_CNT: begin
                    rd_nxt = special_h[`SEL_ERR_CNT_BIT] ? err_cnt_r[h_chan] :
                             to_byte(rx_cnt_r[h_chan]);
                end
                `OFF_TX_CNT: begin
                    rd_nxt = special_h[`SEL_TX_CNT_BIT] ? to_byte(tx_cnt_r[h_chan]) :
                             cfg_mem[cfg_idx];
                end
                default: begin
                    rd_nxt = is_stored(r_off) ? cfg_mem[cfg_idx] : `RESET_BYTE;
                end
            endcase
        end
    end

    // Host answer, one cycle after the strobe
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_rdata_r <= `RESET_BYTE;
            mem_ack_r <= 1'b0;
        end else begin
            mem_rdata_r <= h_rd ? rd_nxt : `RESET_BYTE;
            mem_ack_r <= h_rd | h_wr;
        end
    end

    // Transmitter answer; data holds until the next pop
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_data_r <= `RESET_BYTE;
            tx_valid_r <= 1'b0;
        end else begin
            tx_valid_r <= pop_tx;
            if (pop_tx) begin
                tx_data_r <= tx_mem[slot(tx_pop_chan, tx_rd_r[tx_pop_chan])];
            end
        end
    end

endmodule // octal_uart_mem_reg_decode

// [octal_uart_mem_reg_decode_chk.sv]
`include "octal_uart_mem_reg_decode_consts.vh"

module octal_uart_mem_reg_decode_chk #(
    parameter DL = 7
) (
    input wire clk, // Clock
    input wire reset_n, // Reset, active low
    input wire [11:0] mem_addr, // Window offset
    input wire mem_rd, // Read strobe
    input wire mem_wr, // Write strobe
    input wire [7:0] mem_rdata_r, // Read data
    input wire mem_ack_r, // Done pulse
    input wire tx_pop, // Byte request
    input wire [7:0] tx_data_r, // Byte out
    input wire tx_valid_r // Byte fresh
);
    timeunit 1ns;
    timeprecision 1ps;
    wire rd_only = mem_rd && !mem_wr;
    wire [8:0] off = mem_addr[8:0];
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    ack_follows_a: assert property ((mem_rd || mem_wr) |=> mem_ack_r)
        else $error("ack missing");
    no_stray_a: assert property (!(mem_rd || mem_wr) |=> !mem_ack_r)
        else $error("ack without request");
    quiet_rdata_a: assert property (!rd_only |=> mem_rdata_r == 8'h00)
        else $error("read data without read");
    irq_status_a: assert property (rd_only && off == 9'h002 |=> mem_rdata_r == `IRQ_NONE)
        else $error("interrupt status wrong");
    divisor_hidden_a: assert property (rd_only && off[8:1] == 8'h04 |=> mem_rdata_r == 8'h00)
        else $error("divisor readable");
    unmapped_zero_a: assert property (rd_only && (off == 9'h003 || off[8:3] >= 6'h03 && !off[8])
        |=> mem_rdata_r == 8'h00) else $error("unmapped offset not zero");
    tx_cause_a: assert property (tx_valid_r |-> $past(tx_pop))
        else $error("byte out without request");
    tx_hold_a: assert property (!tx_valid_r |-> $stable(tx_data_r))
        else $error("byte out changed without pop");
endmodule // octal_uart_mem_reg_decode_chk

bind octal_uart_mem_reg_decode octal_uart_mem_reg_decode_chk #(.DL(DL)) i_chk (
    .clk(clk), .reset_n(reset_n), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_rdata_r(mem_rdata_r), .mem_ack_r(mem_ack_r), .tx_pop(tx_pop),
    .tx_data_r(tx_data_r), .tx_valid_r(tx_valid_r));

// [host_model.sv]
module host_model (
    input wire clk, // Clock
    output logic [11:0] mem_addr, // Window offset
    output logic mem_rd, // Read strobe
    output logic mem_wr, // Write strobe
    output logic [7:0] mem_wdata // Write data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] q[$];
    initial begin
        mem_addr = 12'h000;
        mem_rd = 1'b0;
        mem_wr = 1'b0;
        mem_wdata = 8'h00;
    end
    // One request per cycle, entered at the falling edge
    task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [7:0] x);
        mem_addr <= a;
        mem_rd <= !w;
        mem_wr <= w;
        mem_wdata <= w ? d : ~mem_wdata;
        q.push_back(w ? 8'h00 : x);
        @(negedge clk);
    endtask
    // Strobes drop; released address and data lines never keep their last value
    task automatic idle();
        mem_rd <= 1'b0;
        mem_wr <= 1'b0;
        mem_addr <= ~mem_addr;
        mem_wdata <= ~mem_wdata;
        @(negedge clk);
    endtask
endmodule // host_model

// [testbench.sv]
`include "octal_uart_mem_reg_decode_consts.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, reset_n = 1'b0, rx_push = 1'b0, tx_pop = 1'b0;
    logic [2:0] rx_push_chan = 3'h0, tx_pop_chan = 3'h0;
    logic [7:0] rx_push_data = 8'h00, rx_push_status = 8'h00, v, e, t;
    logic [7:0] tq[$], rq[$], chv[8];
    logic [7:0] rw_off[15] = '{8'h01, 8'h04, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F,
        8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h16, 8'h17};
    wire [11:0] mem_addr;
    wire mem_rd, mem_wr, mem_ack_r, tx_valid_r;
    wire [7:0] mem_wdata, mem_rdata_r, tx_data_r;
    int bad_count = 0, n_checks = 0, n_tx = 0, i;
    always #2 clk = ~clk;
    host_model i_host_model (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata));
    octal_uart_mem_reg_decode i_octal_uart_mem_reg_decode (.clk(clk), .reset_n(reset_n),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .mem_rdata_r(mem_rdata_r), .mem_ack_r(mem_ack_r), .rx_push(rx_push),
        .rx_push_chan(rx_push_chan), .rx_push_data(rx_push_data),
        .rx_push_status(rx_push_status), .tx_pop(tx_pop), .tx_pop_chan(tx_pop_chan),
        .tx_data_r(tx_data_r), .tx_valid_r(tx_valid_r));
    always @(negedge clk) begin
        if (mem_ack_r === 1'b1) begin
            e = i_host_model.q.pop_front();
            `CHK(mem_rdata_r, e)
        end
        if (tx_valid_r === 1'b1) begin
            t = tq.pop_front();
            n_tx++;
            `CHK(tx_data_r, t)
        end
    end
    task automatic rd(input logic [11:0] a, input logic [7:0] x);
        i_host_model.acc(1'b0, a, 8'h00, x);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        i_host_model.acc(1'b1, a, d, 8'h00);
    endtask
    task automatic push(input logic [7:0] d, input logic [7:0] s);
        rx_push <= 1'b1;
        rx_push_chan <= 3'h3;
        rx_push_data <= d;
        rx_push_status <= s;
        @(negedge clk);
        rx_push <= 1'b0;
        rx_push_data <= ~d;
        @(negedge clk);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h0B3DC37E));
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        repeat (3) @(negedge clk);
        rd(12'h000, 8'h00);
        for (i = 0; i < 15; i++) begin
            v = $urandom;
            rd({4'h4, rw_off[i]}, 8'h00);
            wr({4'h4, rw_off[i]}, v);
            rd({4'h4, rw_off[i]}, v);
        end
        for (i = 0; i < 8; i++) begin
            chv[i] = $urandom;
            wr({i[2:0], 9'h00B}, chv[i]);
        end
        for (i = 0; i < 8; i++)
            rd({i[2:0], 9'h00B}, chv[i]);
        $display("test registers done");
        wr(12'hE08, 8'h5A);
        wr(12'hE03, 8'hA5);
        wr(12'hEFF, 8'hC3);
        rd(12'hE08, 8'h00);
        rd(12'hE03, 8'h00);
        rd(12'hEFF, 8'h00);
        rd(12'hE02, `IRQ_NONE);
        v = $urandom;
        wr(12'hF7F, v);
        wr(12'hF85, ~v);
        rd(12'hF7F, v);
        rd(12'hF85, ~v);
        rd(12'h605, 8'h60);
        i_host_model.idle();
        $display("test map done");
        for (i = 0; i < 5; i++) begin
            v = $urandom;
            rq.push_back(v);
            push(v, i[0] ? 8'h08 : 8'h00);
        end
        rd(12'h605, 8'h61);
        rd(12'h615, 8'h05);
        wr(12'h607, 8'h40);
        rd(12'h615, 8'h02);
        wr(12'h600, 8'h77);
        for (i = 0; i < 5; i++)
            rd(12'h600, rq[i]);
        rd(12'h600, 8'h00);
        rd(12'h605, 8'h20);
        i_host_model.idle();
        push(8'h11, 8'h00);
        wr(12'h602, 8'h02);
        rd(12'h600, 8'h00);
        $display("test receive done");
        for (i = 0; i < 130; i++) begin
            v = $urandom;
            if (i < 128)
                tq.push_back(v);
            wr(12'hA00, v);
        end
        wr(12'hA07, 8'h80);
        rd(12'hA16, 8'h80);
        rd(12'hA05, 8'h00);
        i_host_model.idle();
        tx_pop <= 1'b1;
        tx_pop_chan <= 3'h5;
        repeat (129) @(negedge clk);
        tx_pop <= 1'b0;
        rd(12'hA05, 8'h60);
        i_host_model.idle();
        for (i = 0; i < 10 && i_host_model.q.size() > 0; i++)
            @(negedge clk);
        `CHK(i_host_model.q.size(), 0)
        `CHK(n_tx, 128)
        `CHK(tq.size(), 0)
        $display("test transmit done");
        end_of_test();
    end
endmodule // testbench
